// ===== ptp_bridge_pkg.sv
`default_nettype none
package ptp_bridge_pkg;

  // ---------------------------------------------------------------
  // Command bus opcodes
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_PEER_MEM_WR = 4'h5;
  localparam logic [3:0] OP_PTP_RD = 4'h6;
  localparam logic [3:0] OP_PTP_WR = 4'h7;
  localparam logic [3:0] OP_LOAD_DN = 4'hc;
  localparam logic [3:0] OP_BYPASS = 4'he;
  localparam logic [3:0] OP_NOP = 4'hf;

  // ---------------------------------------------------------------
  // Transfer type encodings and load-data kind
  // ---------------------------------------------------------------
  localparam logic [1:0] TT_BYTE = 2'h0;
  localparam logic [1:0] TT_LONG = 2'h1;
  localparam logic [1:0] TT_QUAD = 2'h2;
  localparam logic [1:0] TT_ILLEGAL = 2'h3;
  localparam logic [1:0] LDP_PTP = 2'h2;

  // ---------------------------------------------------------------
  // First-beat word layout
  // ---------------------------------------------------------------
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam int TT_HI = 11;
  localparam int TT_LO = 10;
  localparam int MASK_HI = 9;
  localparam int MASK_LO = 2;
  localparam int ADDR_LO = 3;

  // ---------------------------------------------------------------
  // Limits and quadword counts
  // ---------------------------------------------------------------
  localparam logic [2:0] PTP_MAX_OUT = 3'h4;
  localparam logic [3:0] QW_LONG = 4'h4;
  localparam logic [3:0] QW_ONE = 4'h1;

  typedef struct packed {
    logic valid;
    logic first;
    logic [15:0] word;
  } cab_cmd_s;

  typedef struct packed {
    logic valid;
    logic first;
    logic from_ctrl;
    logic [15:0] word;
  } cab_snoop_s;

  typedef struct packed {
    logic valid;
    logic is_write;
    logic [1:0] ttype;
    logic [7:0] mask;
    logic [2:0] addr;
    logic [15:0] bmask;
  } ptp_req_s;

  localparam cab_cmd_s CMD_IDLE = '{valid: 1'b0, first: 1'b0, word: 16'h0000};

endpackage : ptp_bridge_pkg
`default_nettype wire

// ===== ptp_bridge.sv
// Summary of operation
// - Register write is one indivisible bus transaction, no count limit.
// - At most four peer operations outstanding in the controller.
// - Fifth peer request waits until oldest request's queue data drains.
// - Peer read completes on its returning load-data command; full block.
// - Snoop other bridge's peer read and write commands into the tally.
// - Peer write completes on controller's peer-origin memory write.
// - Peer write command carries its transfer length in the mask.
// - No new peer request accepted until earlier ones are issued.
// - Peer write mask flags every quadword moved, full or partial.
// - Byte-mask bypass with 16 bits precedes every peer write.
// - Single-quadword transfer uses only low 8 bypass bits.
// - Bypass bit order ascends with byte address, bit 0 lowest.
// - Priority goes to the bridge with the oldest unmatched bypass.
// - Never two bypass commands without a peer write between.
// - Peer write only after its bypass and while holding priority.
// - Byte type: mask selects bytes of one quadword.
// - Longword type: four quadwords move, mask pairs per quadword.
// - Quadword type: count equals set mask bits, first is lowest.
// - Quadword mask covers up to eight quadwords, one bit each.
// - Bypass uses opcode 1110 over two command cycles.
`timescale 1ns/100ps
`default_nettype none
module ptp_bridge
  import ptp_bridge_pkg::*;
(
  input wire logic clk_in, // 10 MHz system clock
  input wire logic sys_rst_in, // Synchronous reset, active high
  input wire ptp_req_s req_in, // Peer request from the PCI side
  output logic accept_ready_out, // Request can be taken this cycle
  output logic req_refused_out, // Request refused for illegal type or non-quadword write
  input wire logic cab_grant_in, // Command bus granted to us
  output cab_cmd_s cab_cmd_out, // Command bus beat driven
  input wire cab_snoop_s snoop_in, // Beats seen from the other parties
  output logic ptp_prio_out, // We hold peer write priority
  output logic [2:0] ptp_outstanding_out, // Uncompleted peer operations
  output logic [3:0] xfer_qw_out, // Quadwords moved by latched request
  output logic ttype_error_out // Illegal transfer type seen, sticky
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BYP_A = 3'b001,
    ST_BYP_B = 3'b010,
    ST_WAIT_WR = 3'b011,
    ST_WR_A = 3'b100,
    ST_WR_B = 3'b101,
    ST_RD_A = 3'b110,
    ST_RD_B = 3'b111
  } ptp_state_e;

  ptp_state_e state_r, state_nxt;
  ptp_req_s req_r, req_nxt;
  cab_cmd_s cmd_r, cmd_nxt;
  logic [2:0] count_r, count_nxt;
  logic [3:0] qw_r, qw_nxt;
  logic self_pend_r, self_pend_nxt;
  logic other_pend_r, other_pend_nxt;
  logic self_older_r, self_older_nxt;
  logic prio_r, prio_nxt;
  logic ready_r, ready_nxt;
  logic refused_r, refused_nxt;
  logic terr_r, terr_nxt;

  // ---------------------------------------------------------------
  // Snoop decode
  // ---------------------------------------------------------------
  logic snp_head;
  logic [3:0] snp_op;
  logic snp_other_ptp;
  logic snp_other_byp;
  logic snp_other_wr;
  logic snp_done;
  logic snp_bad_tt;

  always_comb begin
    snp_head = snoop_in.valid && snoop_in.first;
    snp_op = snoop_in.word[OP_HI:OP_LO];
    snp_other_ptp = snp_head && !snoop_in.from_ctrl &&
                    (snp_op == OP_PTP_RD || snp_op == OP_PTP_WR);
    snp_other_byp = snp_head && !snoop_in.from_ctrl && snp_op == OP_BYPASS;
    snp_other_wr = snp_head && !snoop_in.from_ctrl && snp_op == OP_PTP_WR;
    snp_done = snp_head && snoop_in.from_ctrl &&
               ((snp_op == OP_LOAD_DN && snoop_in.word[TT_HI:TT_LO] == LDP_PTP) ||
                snp_op == OP_PEER_MEM_WR);
    snp_bad_tt = snp_head && snoop_in.word[TT_HI:TT_LO] == TT_ILLEGAL &&
                 (snp_op == OP_PTP_RD || snp_op == OP_PTP_WR ||
                  (snoop_in.from_ctrl && snp_op == OP_PEER_MEM_WR));
  end

  // ---------------------------------------------------------------
  // Quadword count of an incoming request
  // ---------------------------------------------------------------
  function automatic logic [3:0] qw_count(input logic [1:0] tt, input logic [7:0] m);
    logic [3:0] n;
    n = 4'h0;
    unique case (tt)
      TT_BYTE: n = QW_ONE;
      TT_LONG: n = QW_LONG;
      default: begin
        for (int i = 0; i < 8; i++) begin
          n = n + {3'h0, m[i]};
        end
      end
    endcase
    return n;
  endfunction : qw_count

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic own_issue;
  logic own_byp;
  logic own_wr;
  logic credit_ok;

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    cmd_nxt = CMD_IDLE;
    qw_nxt = qw_r;
    refused_nxt = 1'b0;
    terr_nxt = terr_r || snp_bad_tt;
    own_issue = 1'b0;
    own_byp = 1'b0;
    own_wr = 1'b0;
    credit_ok = count_r < PTP_MAX_OUT;
    unique case (state_r)
      ST_IDLE: begin
        if (req_in.valid && ready_r) begin
          if (req_in.ttype == TT_ILLEGAL ||
              (req_in.is_write && req_in.ttype != TT_QUAD)) begin
            refused_nxt = 1'b1;
          end else begin
            req_nxt = req_in;
            qw_nxt = qw_count(req_in.ttype, req_in.mask);
            if (qw_count(req_in.ttype, req_in.mask) == QW_ONE) begin
              req_nxt.bmask[15:8] = 8'h00;
            end
            state_nxt = req_in.is_write ? ST_BYP_A : ST_RD_A;
          end
        end
      end
      ST_BYP_A: begin
        if (cab_grant_in && !self_pend_r) begin
          cmd_nxt = '{valid: 1'b1, first: 1'b1, word: {OP_BYPASS, 12'h000}};
          own_byp = 1'b1;
          state_nxt = ST_BYP_B;
        end
      end
      ST_BYP_B: begin
        cmd_nxt = '{valid: 1'b1, first: 1'b0, word: req_r.bmask};
        state_nxt = ST_WAIT_WR;
      end
      ST_WAIT_WR: begin
        if (cab_grant_in && prio_r && credit_ok) begin
          cmd_nxt = '{valid: 1'b1, first: 1'b1,
                      word: {OP_PTP_WR, TT_QUAD, req_r.mask, 2'h0}};
          own_issue = 1'b1;
          own_wr = 1'b1;
          state_nxt = ST_WR_A;
        end
      end
      ST_WR_A: begin
        cmd_nxt = '{valid: 1'b1, first: 1'b0, word: {10'h000, req_r.addr, 3'h0}};
        state_nxt = ST_WR_B;
      end
      ST_RD_A: begin
        if (cab_grant_in && credit_ok) begin
          cmd_nxt = '{valid: 1'b1, first: 1'b1,
                      word: {OP_PTP_RD, req_r.ttype, req_r.mask, 2'h0}};
          own_issue = 1'b1;
          state_nxt = ST_RD_B;
        end
      end
      ST_RD_B: begin
        // Address beat follows the head with no gap, then one idle cycle
        cmd_nxt = '{valid: 1'b1, first: 1'b0, word: {10'h000, req_r.addr, 3'h0}};
        state_nxt = ST_WR_B;
      end
      ST_WR_B: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Outstanding tally shared with the other bridge
    count_nxt = count_r + {2'h0, own_issue || snp_other_ptp} -
                {2'h0, snp_done && count_r != 3'h0};
    // Priority tracking between the two bypass senders
    self_pend_nxt = self_pend_r;
    other_pend_nxt = other_pend_r;
    self_older_nxt = self_older_r;
    if (own_byp) begin
      self_pend_nxt = 1'b1;
      self_older_nxt = !other_pend_r;
    end
    if (own_wr) begin
      self_pend_nxt = 1'b0;
      self_older_nxt = 1'b0;
    end
    if (snp_other_byp) begin
      other_pend_nxt = 1'b1;
    end
    if (snp_other_wr) begin
      other_pend_nxt = 1'b0;
      self_older_nxt = self_pend_nxt;
    end
    prio_nxt = self_pend_nxt && (!other_pend_nxt || self_older_nxt);
    ready_nxt = state_nxt == ST_IDLE && !(req_in.valid && ready_r);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      cmd_r <= CMD_IDLE;
      count_r <= 3'h0;
      qw_r <= 4'h0;
      self_pend_r <= 1'b0;
      other_pend_r <= 1'b0;
      self_older_r <= 1'b0;
      prio_r <= 1'b0;
      ready_r <= 1'b0;
      refused_r <= 1'b0;
      terr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      cmd_r <= cmd_nxt;
      count_r <= count_nxt;
      qw_r <= qw_nxt;
      self_pend_r <= self_pend_nxt;
      other_pend_r <= other_pend_nxt;
      self_older_r <= self_older_nxt;
      prio_r <= prio_nxt;
      ready_r <= ready_nxt;
      refused_r <= refused_nxt;
      terr_r <= terr_nxt;
    end
  end

  assign accept_ready_out = ready_r;
  assign req_refused_out = refused_r;
  assign cab_cmd_out = cmd_r;
  assign ptp_prio_out = prio_r;
  assign ptp_outstanding_out = count_r;
  assign xfer_qw_out = qw_r;
  assign ttype_error_out = terr_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_byp_head;
    cmd_r.valid && cmd_r.first && cmd_r.word[OP_HI:OP_LO] == OP_BYPASS;
  endsequence
  sequence s_byp_tail;
    cmd_r.valid && !cmd_r.first;
  endsequence
  sequence s_wr_head;
    cmd_r.valid && cmd_r.first && cmd_r.word[OP_HI:OP_LO] == OP_PTP_WR;
  endsequence

  property p_cnt_max;
    count_r <= PTP_MAX_OUT;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("peer tally above four");

  property p_no_fifth;
    (count_r == PTP_MAX_OUT) |-> !own_issue;
  endproperty
  a_no_fifth: assert property (p_no_fifth) else $error("fifth peer op issued");

  property p_byp_two_beats;
    s_byp_head |=> s_byp_tail;
  endproperty
  a_byp_two_beats: assert property (p_byp_two_beats) else $error("bypass not two beats");

  property p_byp_then_wr;
    s_wr_head |-> $past(self_pend_r) && $past(prio_r);
  endproperty
  a_byp_then_wr: assert property (p_byp_then_wr) else $error("write without bypass/priority");

  property p_no_double_byp;
    s_byp_head |-> !$past(self_pend_r);
  endproperty
  a_no_double_byp: assert property (p_no_double_byp) else $error("two bypass without write");

  property p_wr_quad;
    s_wr_head |-> cmd_r.word[TT_HI:TT_LO] == TT_QUAD && cmd_r.word[MASK_HI:MASK_LO] != 8'h00;
  endproperty
  a_wr_quad: assert property (p_wr_quad) else $error("write mask or type wrong");

  property p_done_dec;
    (snp_done && !own_issue && !snp_other_ptp && count_r != 3'h0) |=>
      count_r == $past(count_r) - 3'h1;
  endproperty
  a_done_dec: assert property (p_done_dec) else $error("completion not counted");

  property p_bad_tt;
    snp_bad_tt |=> ttype_error_out;
  endproperty
  a_bad_tt: assert property (p_bad_tt) else $error("illegal type not flagged");

  property p_accept_idle;
    accept_ready_out |-> state_r == ST_IDLE;
  endproperty
  a_accept_idle: assert property (p_accept_idle) else $error("accept while busy");

  property p_single_qw;
    (state_r == ST_BYP_B && qw_r == QW_ONE) |=> cmd_r.word[15:8] == 8'h00;
  endproperty
  a_single_qw: assert property (p_single_qw) else $error("upper bypass bits set");

endmodule : ptp_bridge
`default_nettype wire

// ===== ctrl_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_peer_model
  import ptp_bridge_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic sys_rst_in, // Synchronous reset
  input wire logic slow_in, // Grant only every other cycle
  input wire logic stall_in, // Withhold the grant
  input wire logic inj_in, // Send one snooped command
  input wire logic from_ctrl_in, // Sender is the controller
  input wire logic [15:0] inj_word_in, // First beat of that command
  output logic grant_out, // Command bus grant
  output cab_snoop_s snoop_out // Beats seen by the bridge
);
  // ---------------------------------------------------------------
  // Controller grant and snooped traffic
  // ---------------------------------------------------------------
  logic phase_r;
  logic beat2_r;
  logic [15:0] last_r;

  always_ff @(posedge clk_in) begin
    phase_r <= sys_rst_in ? 1'b0 : ~phase_r;
    beat2_r <= inj_in;
    last_r <= snoop_out.word;
  end

  assign grant_out = ~stall_in & (~slow_in | phase_r);

  // Released bus shows a changing pattern, never the last value
  always_comb begin
    snoop_out.valid = inj_in | beat2_r;
    snoop_out.first = inj_in;
    snoop_out.from_ctrl = from_ctrl_in;
    snoop_out.word = inj_in ? inj_word_in : ~last_r;
  end
endmodule : ctrl_peer_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ptp_bridge_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  ptp_req_s req = '0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic inj = 1'b0;
  logic fc = 1'b0;
  logic [15:0] iw = 16'h0000;
  logic grant, ready, refused, prio, terr;
  cab_cmd_s cmd;
  cab_snoop_s snoop;
  logic [2:0] tally;
  logic [3:0] qw;
  logic [16:0] expq[$];
  int mismatches = 0;
  int tests_run = 0;
  int refusals = 0;
  logic [7:0] rnd = 8'h44;
  logic [7:0] m;
  logic [15:0] bm;

  always #50 clk_in = ~clk_in;

  ptp_bridge dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .accept_ready_out(ready), .req_refused_out(refused), .cab_grant_in(grant),
    .cab_cmd_out(cmd), .snoop_in(snoop), .ptp_prio_out(prio),
    .ptp_outstanding_out(tally), .xfer_qw_out(qw), .ttype_error_out(terr));
  ctrl_peer_model peer (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
    .stall_in(stall), .inj_in(inj), .from_ctrl_in(fc), .inj_word_in(iw),
    .grant_out(grant), .snoop_out(snoop));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic push_cmd(input logic wr, input logic [1:0] tt, input logic [7:0] mk,
    input logic [15:0] bk);
    if (wr) begin
      expq.push_back({1'b1, OP_BYPASS, 12'h000});
      expq.push_back({1'b0, ($countones(mk) == 1) ? {8'h00, bk[7:0]} : bk});
    end
    expq.push_back({1'b1, wr ? OP_PTP_WR : OP_PTP_RD, tt, mk, 2'b00});
    expq.push_back({1'b0, 10'h000, rnd[2:0], 3'h0});
  endtask : push_cmd

  task automatic send(input logic wr, input logic [1:0] tt, input logic [7:0] mk,
    input logic [15:0] bk);
    int n;
    n = 0;
    @(negedge clk_in);
    req = '{valid: 1'b1, is_write: wr, ttype: tt, mask: mk, addr: rnd[2:0], bmask: bk};
    while (ready !== 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    check("request taken", n < 100, 1);
    @(negedge clk_in);
    req.valid = 1'b0;
  endtask : send

  task automatic wait_idle();
    int n;
    n = 0;
    while ((expq.size() != 0 || ready !== 1'b1) && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    check("idle", n < 200, 1);
  endtask : wait_idle

  task automatic snoop_cmd(input logic f, input logic [15:0] w);
    @(negedge clk_in);
    inj = 1'b1;
    fc = f;
    iw = w;
    @(negedge clk_in);
    inj = 1'b0;
    @(negedge clk_in);
  endtask : snoop_cmd

  // ---------------------------------------------------------------
  // Output watchers and scenarios
  // ---------------------------------------------------------------
  always @(negedge clk_in) begin
    if (refused === 1'b1) refusals++;
    if (cmd.valid === 1'b1) begin
      if (expq.size() == 0) check("unexpected beat", 1, 0);
      else check("beat", {cmd.first, cmd.word}, expq.pop_front());
    end
  end

  initial begin
    #(100 * 20000);
    check("watchdog", 1, 0);
    summarize();
  end

  initial begin
    repeat (12) @(negedge clk_in);
    check("ready in reset", ready, 0);
    check("tally in reset", tally, 0);
    sys_rst_in = 1'b0;
    for (int t = 0; t < 3; t++) begin
      rnd = lfsr(rnd);
      m = rnd | 8'h01;
      push_cmd(1'b0, t[1:0], m, 16'h0000);
      send(1'b0, t[1:0], m, 16'h0000);
      wait_idle();
      check("qw", qw, t == 0 ? 1 : t == 1 ? 4 : $countones(m));
      check("tally", tally, t + 1);
    end
    snoop_cmd(1'b0, {OP_PTP_RD, TT_QUAD, 8'h01, 2'b00});
    check("peer read counted", tally, 4);
    rnd = lfsr(rnd);
    m = rnd | 8'h81;
    bm = {rnd, lfsr(rnd)};
    push_cmd(1'b1, TT_QUAD, m, bm);
    send(1'b1, TT_QUAD, m, bm);
    repeat (20) @(negedge clk_in);
    check("held at four", expq.size(), 2);
    check("prio after bypass", prio, 1);
    snoop_cmd(1'b1, {OP_LOAD_DN, LDP_PTP, 10'h000});
    wait_idle();
    check("tally", tally, 4);
    check("prio released", prio, 0);
    for (int i = 0; i < 5; i++) snoop_cmd(1'b1, {OP_PEER_MEM_WR, TT_QUAD, 8'h01, 2'b00});
    check("drained", tally, 0);
    stall = 1'b1;
    rnd = lfsr(rnd);
    push_cmd(1'b0, TT_LONG, rnd, 16'h0000);
    send(1'b0, TT_LONG, rnd, 16'h0000);
    repeat (10) @(negedge clk_in);
    check("read waits for grant", expq.size(), 2);
    check("busy while stalled", ready, 0);
    stall = 1'b0;
    wait_idle();
    check("qw long", qw, 4);
    slow = 1'b1;
    rnd = lfsr(rnd);
    m = 8'h01 << rnd[2:0];
    bm = {lfsr(rnd), rnd};
    push_cmd(1'b1, TT_QUAD, m, bm);
    send(1'b1, TT_QUAD, m, bm);
    wait_idle();
    check("single qw", qw, 1);
    slow = 1'b0;
    snoop_cmd(1'b0, {OP_BYPASS, 12'h000});
    push_cmd(1'b1, TT_QUAD, 8'h03, bm);
    send(1'b1, TT_QUAD, 8'h03, bm);
    repeat (20) @(negedge clk_in);
    check("write waits for priority", expq.size(), 2);
    check("prio other", prio, 0);
    snoop_cmd(1'b0, {OP_PTP_WR, TT_QUAD, 8'h01, 2'b00});
    wait_idle();
    check("tally", tally, 4);
    send(1'b1, TT_BYTE, 8'h01, 16'h0001);
    send(1'b0, TT_ILLEGAL, 8'h01, 16'h0000);
    wait_idle();
    check("refusals", refusals, 2);
    snoop_cmd(1'b1, {OP_PEER_MEM_WR, TT_ILLEGAL, 8'h01, 2'b00});
    check("illegal type flagged", terr, 1);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check("flag cleared", terr, 0);
    check("tally cleared", tally, 0);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    check("ready after reset", ready, 1);
    summarize();
  end
endmodule : tb
`default_nettype wire
